// file: rtl/adcw_pkg.sv
package adcw_pkg;

  // Nominal master clock; all filter timing counts master clock edges
  localparam int MCLK_NOM_HZ = 32768;
  localparam int REF_CLK_HZ = 100_000_000;

  // Output rate select and its value after reset (15.0 Hz setting)
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam int TICK_W = 16;
  // Master clock edges per output word for each rate code
  localparam logic [15:0] RATE_TICKS [8] = '{
    16'h0889, 16'h0444, 16'h0222, 16'h1111,
    16'h2222, 16'h00A2, 16'h0111, 16'h0186
  };

  // Result word layout
  localparam int WORD_W = 24;
  localparam int DATA20_W = 20;
  localparam int DATA16_W = 16;
  localparam int RAW_W = 22;
  localparam int FLAG_OD_BIT = 1;
  localparam int FLAG_OF_BIT = 0;
  localparam logic [3:0] FILL16 = 4'hF;
  localparam logic [1:0] ZERO2 = 2'h0;
  localparam logic signed [21:0] BIP_MAX = 22'sh07_FFFF;
  localparam logic signed [21:0] BIP_MIN = -22'sh08_0000;
  localparam logic signed [21:0] UNI_MAX = 22'sh0F_FFFF;
  localparam logic signed [21:0] UNI_MIN = 22'sh00_0000;
  localparam logic [23:0] WORD_RST = 24'h00_0000;

  // Oscillator start-up after sleep
  localparam int SLEEP_WAKE_MS = 500;
  localparam int SLEEP_WAKE_CYC = (REF_CLK_HZ / 1000) * SLEEP_WAKE_MS;
  localparam int WAKE_W = 26;

  // Serial flag read-out
  localparam logic [4:0] PORT_CLR_CLKS = 5'd8;
  localparam logic [4:0] PORT_WORD_CLKS = 5'd24;

  // Configuration bits after reset: normal power, standby select, bipolar
  typedef struct packed {
    logic [2:0] rate_select_field;
    logic low_power_bit;
    logic power_save_select_bit;
    logic unipolar_bit;
    logic port_flag_enable;
  } adcw_cfg_s;
  localparam adcw_cfg_s CFG_RST = '{RATE_RST, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic command_valid_bit;
    logic power_save_run_bit;
    logic continuous_bit;
    logic single_conversion_bit;
    logic [3:0] other_bits;
  } adcw_cmd_s;

  typedef struct packed {
    logic done_flag;
    logic overrange_flag;
    logic oscillation_detect_flag;
    logic converting;
  } adcw_stat_s;

  typedef enum logic [4:0] {
    PWR_NORMAL = 5'b00001,
    PWR_LOW = 5'b00010,
    PWR_STANDBY = 5'b00100,
    PWR_SLEEP = 5'b01000,
    PWR_WAKE = 5'b10000
  } adcw_pwr_e;

  typedef enum logic [2:0] {
    LNK_IDLE = 3'b001,
    LNK_CLEAR = 3'b010,
    LNK_SHIFT = 3'b100
  } adcw_lnk_e;

endpackage

// file: rtl/adcw_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is visible
module adcw_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;

  // Reset to zero; the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_q <= '0;
    end else begin
      meta_q <= d_in;
      q_q <= meta_q;
    end
  end

  assign q_out = q_q;
endmodule

// file: rtl/adcw_fmt.sv
`timescale 1ns/1ps
// Clamps a raw filter result and packs the 24-bit result word
module adcw_fmt
  import adcw_pkg::*;
(
  input wire logic signed [RAW_W-1:0] raw_in,
  input wire logic unipolar_in,
  input wire logic res20_in,
  input wire logic osc_in,
  output logic [WORD_W-1:0] word_out,
  output logic ovr_out
);
  wire logic signed [RAW_W-1:0] hi_lim;
  wire logic signed [RAW_W-1:0] lo_lim;
  wire logic over_hi;
  wire logic under_lo;
  wire logic signed [RAW_W-1:0] clamped;
  wire logic [DATA20_W-1:0] d20;

  // Limits follow the range: zero floor when unipolar
  assign hi_lim = unipolar_in ? UNI_MAX : BIP_MAX;
  assign lo_lim = unipolar_in ? UNI_MIN : BIP_MIN;
  assign over_hi = raw_in > hi_lim;
  assign under_lo = raw_in < lo_lim;
  assign ovr_out = over_hi | under_lo;
  assign clamped = over_hi ? hi_lim : (under_lo ? lo_lim : raw_in);
  // Low 20 bits give straight binary or two's complement directly
  assign d20 = clamped[DATA20_W-1:0];

  // Narrow variant keeps the top 16 bits, so its bipolar limits are 7FFF/8000
  assign word_out = res20_in ?
    {d20, ZERO2, osc_in, ovr_out} :
    {d20[DATA20_W-1:DATA20_W-DATA16_W], FILL16, ZERO2, osc_in, ovr_out};
endmodule

// file: rtl/adcw_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Rate from 3-bit field; resets to 15 Hz
// - Eight rates, timing counts master clock edges
// - Unipolar straight binary, bipolar two's complement
// - 24-bit word sent MSB first
// - 16-bit: data, four ones, two zeros, flags
// - 20-bit: data, two zeros, two flags
// - Results clamp at code limits
// - Overrange flag set beyond full scale
// - Overrange flag clears on clean word
// - Oscillation flag set while modulator oscillates
// - Oscillation flag clears on the next word loaded while modulator stable
// - Normal power mode after reset
// - Low-power bit selects reduced power, still converting
// - Valid power-save command halts filter and analog
// - Select bit low gives standby, oscillator running
// - Select bit high sleeps; 500 ms wake-up
// - Data-class reads clear done; config read does not
// - Single-conversion command converts once, sets done
module adcw_core
  import adcw_pkg::*;
#(
  parameter int WAKE_CYCLES = SLEEP_WAKE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic master_clock_input_in,
  input wire logic res20_in,
  input wire logic cfg_write_in,
  input wire adcw_cfg_s cfg_in,
  input wire logic cmd_valid_in,
  input wire adcw_cmd_s cmd_in,
  input wire logic data_read_in,
  input wire logic signed [RAW_W-1:0] raw_sample_in,
  input wire logic osc_detect_in,
  input wire logic link_clk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output adcw_cfg_s cfg_out,
  output adcw_stat_s stat_out,
  output logic [WORD_W-1:0] result_word_out,
  output adcw_pwr_e power_mode_out,
  output logic osc_enable_out,
  output logic analog_enable_out,
  output logic filter_run_out,
  output logic sdo_out,
  output logic sdo_oe_out
);

  // ---------------- Core domain state ----------------
  adcw_cfg_s cfg_q;
  adcw_pwr_e pwr_q, pwr_d;
  logic [WAKE_W-1:0] wake_cnt_q;
  logic run_q, cont_q;
  logic [TICK_W-1:0] tick_q;
  logic mclk_prev_q;
  logic [WORD_W-1:0] word_q;
  logic done_q, ovr_q, osc_q;
  logic ack_seen_q;

  wire logic mclk_s;
  wire logic ack_s;
  wire logic busy_s;
  wire logic [WORD_W-1:0] fmt_word;
  wire logic fmt_ovr;

  // Master clock pin is asynchronous to the reference clock
  adcw_sync #(.W(1)) u_mclk_sync (
    .clk_in(ref_clk_in),
    .rst_in(sys_rst_in),
    .d_in(master_clock_input_in),
    .q_out(mclk_s)
  );

  adcw_fmt u_fmt (
    .raw_in(raw_sample_in),
    .unipolar_in(cfg_q.unipolar_bit),
    .res20_in(res20_in),
    .osc_in(osc_detect_in),
    .word_out(fmt_word),
    .ovr_out(fmt_ovr)
  );

  // Command decode; commands without the valid bit are ignored
  wire logic cmd_take = cmd_valid_in & cmd_in.command_valid_bit;
  wire logic cmd_ps = cmd_take & cmd_in.power_save_run_bit;
  wire logic cmd_wake = cmd_take & ~cmd_in.power_save_run_bit;
  wire logic start_bits_ok = ~cmd_in.power_save_run_bit & (cmd_in.other_bits == 4'h0);
  wire logic cmd_sc = cmd_take & start_bits_ok & cmd_in.single_conversion_bit
    & ~cmd_in.continuous_bit;
  wire logic cmd_cc = cmd_take & start_bits_ok & cmd_in.continuous_bit
    & ~cmd_in.single_conversion_bit;
  wire logic cmd_start = cmd_sc | cmd_cc;

  // Conversion timing: one word per RATE_TICKS master clock edges
  wire logic mclk_rise = mclk_s & ~mclk_prev_q;
  wire logic active = (pwr_q == PWR_NORMAL) | (pwr_q == PWR_LOW);
  wire logic [TICK_W-1:0] tick_last = RATE_TICKS[cfg_q.rate_select_field] - 16'h0001;
  wire logic conv_done = run_q & active & mclk_rise & (tick_q == tick_last);
  wire logic wake_done = (wake_cnt_q == WAKE_W'(WAKE_CYCLES - 1));
  // Link read-out finished: toggle from the link domain changed
  wire logic link_ack = ack_s ^ ack_seen_q;
  // Never overwrite the word while the link is copying it
  wire logic word_load = conv_done & ~busy_s;

  // Configuration register; reset gives 15 Hz, normal power, standby select
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cfg_q <= CFG_RST;
    end else if (cfg_write_in) begin
      cfg_q <= cfg_in;
    end
  end

  // Power mode next state
  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_NORMAL, PWR_LOW: begin
        if (cmd_ps) begin
          pwr_d = cfg_q.power_save_select_bit ? PWR_SLEEP : PWR_STANDBY;
        end else begin
          pwr_d = cfg_q.low_power_bit ? PWR_LOW : PWR_NORMAL;
        end
      end
      PWR_STANDBY: begin
        // Oscillator kept alive, so return is immediate
        if (cmd_wake) begin
          pwr_d = cfg_q.low_power_bit ? PWR_LOW : PWR_NORMAL;
        end
      end
      PWR_SLEEP: begin
        if (cmd_wake) begin
          pwr_d = PWR_WAKE;
        end
      end
      PWR_WAKE: begin
        if (wake_done) begin
          pwr_d = cfg_q.low_power_bit ? PWR_LOW : PWR_NORMAL;
        end
      end
      default: begin
        pwr_d = PWR_NORMAL;
      end
    endcase
  end

  // Power mode register and start-up counter
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pwr_q <= PWR_NORMAL;
      wake_cnt_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      wake_cnt_q <= (pwr_q == PWR_WAKE) ? wake_cnt_q + 1'b1 : '0;
    end
  end

  // Conversion sequencer; a new start restarts the convolution
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      run_q <= 1'b0;
      cont_q <= 1'b0;
      tick_q <= '0;
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= mclk_s;
      if (cmd_start) begin
        run_q <= 1'b1;
        cont_q <= cmd_cc;
        tick_q <= '0;
      end else if (cmd_take) begin
        // Any other valid command ends continuous mode
        run_q <= 1'b0;
        cont_q <= 1'b0;
        tick_q <= '0;
      end else if (conv_done) begin
        run_q <= cont_q;
        tick_q <= '0;
      end else if (run_q & active & mclk_rise) begin
        tick_q <= tick_q + 1'b1;
      end
    end
  end

  // Word and both flags load in the same edge
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      word_q <= WORD_RST;
      ovr_q <= 1'b0;
      osc_q <= 1'b0;
    end else if (word_load) begin
      word_q <= fmt_word;
      ovr_q <= fmt_ovr;
      osc_q <= osc_detect_in;
    end
  end

  // Done flag: a completion wins over a same-cycle clear
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      done_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_seen_q <= ack_s;
      if (conv_done) begin
        done_q <= 1'b1;
      end else if (data_read_in | link_ack) begin
        done_q <= 1'b0;
      end
    end
  end

  // Core outputs
  assign cfg_out = cfg_q;
  assign stat_out = '{done_q, ovr_q, osc_q, run_q};
  assign result_word_out = word_q;
  assign power_mode_out = pwr_q;
  assign osc_enable_out = pwr_q != PWR_SLEEP;
  assign analog_enable_out = active;
  assign filter_run_out = run_q & active;

  // ---------------- Link domain (serial clock) ----------------
  // Flag mode only: the pending word is announced by SDO going low
  wire logic pend = done_q & cfg_q.port_flag_enable;
  wire logic link_rst;
  wire logic pend_l;
  adcw_lnk_e lnk_q;
  logic [4:0] lcnt_q;
  logic [WORD_W-1:0] sh_q;
  logic ack_tgl_q;
  logic busy_q;

  // Reset reaches the link only while its clock runs
  adcw_sync #(.W(1)) u_rst_sync (
    .clk_in(link_clk_in),
    .rst_in(1'b0),
    .d_in(sys_rst_in),
    .q_out(link_rst)
  );

  adcw_sync #(.W(1)) u_pend_sync (
    .clk_in(link_clk_in),
    .rst_in(link_rst),
    .d_in(pend),
    .q_out(pend_l)
  );

  // Busy level and ack toggle back to the core clock
  adcw_sync #(.W(2)) u_back_sync (
    .clk_in(ref_clk_in),
    .rst_in(sys_rst_in),
    .d_in({busy_q, ack_tgl_q}),
    .q_out({busy_s, ack_s})
  );

  // Eight zero clocks open the read, then 24 clocks shift the word and clear the flag
  always_ff @(posedge link_clk_in) begin
    if (link_rst | cs_n_in) begin
      lnk_q <= LNK_IDLE;
      lcnt_q <= '0;
      busy_q <= 1'b0;
      if (link_rst) begin
        ack_tgl_q <= 1'b0;
        sh_q <= WORD_RST;
      end
    end else begin
      unique case (lnk_q)
        LNK_IDLE: begin
          if (pend_l & ~sdi_in) begin
            lnk_q <= LNK_CLEAR;
            lcnt_q <= 5'd1;
            busy_q <= 1'b1;
          end
        end
        LNK_CLEAR: begin
          if (sdi_in) begin
            lnk_q <= LNK_IDLE;
            busy_q <= 1'b0;
          end else if (lcnt_q == PORT_CLR_CLKS - 5'd1) begin
            sh_q <= word_q;
            lcnt_q <= '0;
            lnk_q <= LNK_SHIFT;
          end else begin
            lcnt_q <= lcnt_q + 5'd1;
          end
        end
        LNK_SHIFT: begin
          sh_q <= {sh_q[WORD_W-2:0], 1'b0};
          if (lcnt_q == PORT_WORD_CLKS - 5'd1) begin
            lnk_q <= LNK_IDLE;
            lcnt_q <= '0;
            busy_q <= 1'b0;
            ack_tgl_q <= ~ack_tgl_q;
          end else begin
            lcnt_q <= lcnt_q + 5'd1;
          end
        end
      endcase
    end
  end

  // Pin drive: word MSB first while shifting, otherwise inverted flag
  assign sdo_out = (lnk_q == LNK_SHIFT) ? sh_q[WORD_W-1] : ~pend;
  assign sdo_oe_out = ~cs_n_in & cfg_q.port_flag_enable;

endmodule

// file: dv/adcw_core_properties.sv
`timescale 1ns/1ps
// Ties result word, flags and power modes to their causes
module adcw_chk
  import adcw_pkg::*;
#(
  parameter int WAKE_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic res20_in,
  input wire logic cfg_write_in,
  input wire adcw_cfg_s cfg_in,
  input wire logic cmd_valid_in,
  input wire adcw_cmd_s cmd_in,
  input wire logic data_read_in,
  input wire adcw_cfg_s cfg_out,
  input wire adcw_stat_s stat_out,
  input wire logic [WORD_W-1:0] result_word_out,
  input wire adcw_pwr_e power_mode_out,
  input wire logic osc_enable_out,
  input wire logic analog_enable_out,
  input wire logic filter_run_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] wake_q;
  logic [7:0] wake_d;
  wire ps_cmd = cmd_valid_in && cmd_in.command_valid_bit && cmd_in.power_save_run_bit;
  wire run_mode = power_mode_out inside {PWR_NORMAL, PWR_LOW};
  // Cycles spent waking; saturates so a stuck wake keeps failing
  assign wake_d = (power_mode_out != PWR_WAKE) ? 8'h00 : wake_q + 8'(wake_q != 8'hFF);
  always_ff @(posedge ref_clk_in) begin
    wake_q <= wake_d;
  end
  sequence s_sleep_exit;
    power_mode_out == PWR_SLEEP ##1 power_mode_out == PWR_WAKE;
  endsequence
  sequence s_new_word;
    !$stable(result_word_out);
  endsequence
  chk_reset_values: assert property ($fell(sys_rst_in) |->
    cfg_out == CFG_RST && power_mode_out == PWR_NORMAL) else $error("bad reset values");
  chk_cfg_load: assert property (cfg_write_in |=> cfg_out == $past(cfg_in))
    else $error("config not loaded");
  chk_start_conv: assert property (cmd_valid_in && cmd_in == 8'h90 && run_mode |=>
    stat_out.converting && filter_run_out) else $error("conversion not started");
  chk_word_hold: assert property (s_new_word |-> stat_out.done_flag)
    else $error("word changed without completion");
  chk_word_tail: assert property (s_new_word |-> result_word_out[3:0] ==
    {ZERO2, stat_out.oscillation_detect_flag, stat_out.overrange_flag}
    && (res20_in || result_word_out[7:4] == FILL16)) else $error("bad word tail");
  chk_ps_enter: assert property (ps_cmd && run_mode |=> power_mode_out ==
    ($past(cfg_out.power_save_select_bit) ? PWR_SLEEP : PWR_STANDBY)) else $error("bad save");
  chk_save_outs: assert property (power_mode_out inside {PWR_STANDBY, PWR_SLEEP} |->
    !analog_enable_out && !filter_run_out && osc_enable_out == (power_mode_out == PWR_STANDBY))
    else $error("bad save outputs");
  chk_wake_hold: assert property (s_sleep_exit |-> (power_mode_out == PWR_WAKE) [*8])
    else $error("wake cut short");
  chk_wake_bound: assert property (wake_q <= WAKE_CYCLES + 1)
    else $error("wake too long");
  chk_read_clears: assert property (data_read_in |-> ##[1:2] !stat_out.done_flag)
    else $error("done not cleared");
endmodule
bind adcw_core adcw_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.ref_clk_in, .sys_rst_in,
  .res20_in, .cfg_write_in, .cfg_in, .cmd_valid_in, .cmd_in, .data_read_in, .cfg_out,
  .stat_out, .result_word_out, .power_mode_out, .osc_enable_out, .analog_enable_out,
  .filter_run_out);

// file: dv/adcw_host.sv
`timescale 1ns/1ps
// Host side of the serial port; clock stands still outside its tasks
module adcw_host (
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic link_clk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial begin
    link_clk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b1;
  end
  // Clocks with the port deselected; they move the link synchronisers while the frame logic stays idle
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #80;
      link_clk_out = 1'b1;
      #80;
      link_clk_out = 1'b0;
    end
  endtask

  // Flag seen first, then eight zero clocks, then 24 data clocks
  task automatic read_word(output logic [24:0] w);
    logic line;
    w = 25'h000_0000;
    // Pending flag needs two link edges to cross before the frame starts
    idle_clocks(2);
    #3;
    cs_n_out = 1'b0;
    sdi_out = 1'b0;
    #80;
    for (int k = 1; k <= 32; k++) begin
      line = sdo_oe_in ? sdo_in : 1'bx;
      if (k == 1 || k > 8) w = {w[23:0], line};
      link_clk_out = 1'b1;
      #80;
      link_clk_out = 1'b0;
      #80;
    end
    cs_n_out = 1'b1;
    sdi_out = 1'b1;
  endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb
  import adcw_pkg::*;
();
  logic ref_clk_in, sys_rst_in, master_clock_input_in, res20_in, cfg_write_in;
  logic cmd_valid_in, data_read_in, osc_detect_in, sdo_out, sdo_oe_out;
  logic osc_enable_out, analog_enable_out, filter_run_out;
  wire link_clk_in, cs_n_in, sdi_in;
  adcw_cfg_s cfg_in, cfg_out;
  adcw_cmd_s cmd_in;
  adcw_stat_s stat_out;
  adcw_pwr_e power_mode_out;
  logic signed [RAW_W-1:0] raw_sample_in;
  logic [WORD_W-1:0] result_word_out;
  int err_count, checked;

  adcw_core #(.WAKE_CYCLES(20)) uut (.ref_clk_in, .sys_rst_in, .master_clock_input_in,
    .res20_in, .cfg_write_in, .cfg_in, .cmd_valid_in, .cmd_in, .data_read_in,
    .raw_sample_in, .osc_detect_in, .link_clk_in, .cs_n_in, .sdi_in, .cfg_out, .stat_out,
    .result_word_out, .power_mode_out, .osc_enable_out, .analog_enable_out,
    .filter_run_out, .sdo_out, .sdo_oe_out);
  adcw_host host (.sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out), .link_clk_out(link_clk_in),
    .cs_n_out(cs_n_in), .sdi_out(sdi_in));

  // Core clock
  always #5 ref_clk_in = ~ref_clk_in;
  // Time base compressed past the rated ceiling: a word at the rated clock would
  // overrun the run budget, and the design only counts edges, so ratios hold
  always #40 master_clock_input_in = ~master_clock_input_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic put_cfg(input adcw_cfg_s c);
    @(negedge ref_clk_in);
    cfg_in = c;
    cfg_write_in = 1'b1;
    @(negedge ref_clk_in);
    cfg_write_in = 1'b0;
  endtask

  task automatic put_cmd(input adcw_cmd_s c);
    @(negedge ref_clk_in);
    cmd_in = c;
    cmd_valid_in = 1'b1;
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
  endtask

  function automatic logic [23:0] exp_word(input logic signed [21:0] raw, input logic u, r, o);
    logic signed [21:0] lo, hi, c;
    logic ovr;
    lo = u ? UNI_MIN : BIP_MIN;
    hi = u ? UNI_MAX : BIP_MAX;
    ovr = raw > hi || raw < lo;
    c = raw > hi ? hi : (raw < lo ? lo : raw);
    exp_word = r ? {c[19:0], 2'h0, o, ovr} : {c[19:4], 4'hF, 2'h0, o, ovr};
  endfunction

  // One conversion; its length must follow the rate code's tick count
  task automatic convert(input logic [2:0] rc, input logic [7:0] c = 8'h90);
    int n, e;
    e = RATE_TICKS[rc] * 8;
    put_cmd(c);
    n = 0;
    while (stat_out.done_flag !== 1'b1) begin
      @(negedge ref_clk_in);
      n++;
      if (n > 40000) begin
        err_count++;
        complete_run();
      end
    end
    // Edge phase and synchroniser lag: done lands from one tick before to two ticks after e
    chk(32'(n >= e - 8 && n <= e + 16), 32'h1);
  endtask

  task automatic rd_clear(input logic [23:0] w);
    @(negedge ref_clk_in);
    data_read_in = 1'b1;
    @(negedge ref_clk_in);
    data_read_in = 1'b0;
    @(negedge ref_clk_in);
    chk(32'(stat_out.done_flag), 32'h0);
    chk(32'(result_word_out), 32'(w));
  endtask

  // Second reset with the link clock running, so the link side starts known
  task automatic link_reset();
    @(negedge ref_clk_in);
    sys_rst_in = 1'b1;
    host.idle_clocks(4);
    @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    host.idle_clocks(3);
    @(negedge ref_clk_in);
  endtask

  task automatic t_reset();
    chk(32'(cfg_out), 32'(CFG_RST));
    chk(32'({power_mode_out, osc_enable_out, analog_enable_out, filter_run_out}),
      32'({PWR_NORMAL, 3'h6}));
    convert(3'h0);
    rd_clear(exp_word(raw_sample_in, 1'b0, res20_in, 1'b0));
  endtask

  // Each entry: unipolar, 20-bit, oscillating, raw sample
  task automatic t_format();
    logic [24:0] tv [8] = '{{3'h2, 22'h01_2345}, {3'h2, 22'h08_0000}, {3'h2, 22'h37_FFFF},
      {3'h6, 22'h3F_FFFF}, {3'h6, 22'h10_0000}, {3'h1, 22'h3F_FFFB}, {3'h4, 22'h0F_FFFF},
      {3'h0, 22'h08_0000}};
    logic u, r, o;
    logic [23:0] w;
    for (int i = 0; i < 8; i++) begin
      {u, r, o, raw_sample_in} = tv[i];
      res20_in = r;
      osc_detect_in = o;
      put_cfg({3'h5, 2'h0, u, 1'b0});
      convert(3'h5);
      w = exp_word(raw_sample_in, u, r, o);
      chk(32'(result_word_out), 32'(w));
      rd_clear(w);
    end
  endtask

  task automatic t_power();
    int n;
    put_cfg({3'h5, 4'h8});
    repeat (3) @(negedge ref_clk_in);
    chk(32'({power_mode_out, analog_enable_out}), 32'({PWR_LOW, 1'b1}));
    convert(3'h5);
    rd_clear(exp_word(raw_sample_in, 1'b0, res20_in, osc_detect_in));
    put_cfg({3'h5, 4'h0});
    put_cmd(8'h90);
    put_cmd(8'hC0);
    chk(32'({power_mode_out, osc_enable_out, analog_enable_out, filter_run_out}),
      32'({PWR_STANDBY, 3'h4}));
    put_cmd(8'h80);
    chk(32'(power_mode_out), 32'(PWR_NORMAL));
    put_cfg({3'h5, 4'h4});
    put_cmd(8'hC0);
    chk(32'({power_mode_out, osc_enable_out, analog_enable_out}), 32'({PWR_SLEEP, 2'h0}));
    put_cmd(8'h80);
    n = 0;
    // Host waits out the oscillator start-up before relying on the converter
    while (power_mode_out !== PWR_NORMAL && n < 100) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk(32'(n >= 18 && n <= 22), 32'h1);
    // Continuous run keeps converting past the first word until stopped
    convert(3'h5, 8'hA0);
    chk(32'({stat_out.converting, filter_run_out}), 32'h3);
    put_cmd(8'h80);
    chk(32'({stat_out.converting, filter_run_out}), 32'h0);
    rd_clear(exp_word(raw_sample_in, 1'b0, res20_in, osc_detect_in));
  endtask

  task automatic t_link();
    logic [24:0] lw;
    logic [23:0] w;
    put_cfg({3'h5, 4'h1});
    res20_in = 1'b1;
    raw_sample_in = 22'h05_A5C3;
    w = exp_word(raw_sample_in, 1'b0, 1'b1, osc_detect_in);
    convert(3'h5);
    host.read_word(lw);
    chk(32'(lw), 32'({1'b0, w}));
    repeat (8) @(negedge ref_clk_in);
    chk(32'({stat_out.done_flag, sdo_oe_out}), 32'h0);
  endtask

  initial begin
    ref_clk_in = 1'b0;
    master_clock_input_in = 1'b0;
    sys_rst_in = 1'b1;
    {res20_in, cfg_write_in, cmd_valid_in, data_read_in, osc_detect_in} = 5'h00;
    cfg_in = CFG_RST;
    cmd_in = 8'h00;
    raw_sample_in = 22'h00_0000;
    err_count = 0;
    checked = 0;
    repeat (20) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    link_reset();
    t_reset();
    t_format();
    t_power();
    t_link();
    complete_run();
  end
endmodule
